// >>> hdl/shc_defines.svh
// Offsets, reset values and timing counts for the hub config slave
`ifndef SHC_DEFINES_SVH
`define SHC_DEFINES_SVH

// ----------------------------------------
// Register indices (8-bit register address field)
// ----------------------------------------
`define SHC_REG_PORT_DIS_BUS 8'h0A
`define SHC_REG_MAXP_SELF 8'h0B
`define SHC_REG_MAXP_BUS 8'h0C
`define SHC_REG_CTRL_I_SELF 8'h0D
`define SHC_REG_CTRL_I_BUS 8'h0E
`define SHC_REG_PGOOD_DELAY 8'h0F
`define SHC_REG_DL_DONE 8'h1F

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define SHC_PORT_DIS_MASK 8'h0E
`define SHC_DL_DONE_BIT 0
`define SHC_RST_PORT_DIS 8'h00
`define SHC_RST_MAXP 8'h00
`define SHC_RST_CTRL_I 8'h32
`define SHC_RST_PGOOD 8'h00
`define SHC_UNIT_MA 2
`define SHC_UNIT_MS 2

// ----------------------------------------
// Strap and address values
// ----------------------------------------
`define SHC_SEL_SMBUS 2'b11
`define SHC_SLAVE_ADDR 7'h2C
`define SHC_BYTE_LAST 3'h7

`endif

// >>> hdl/shc_pkg.sv
// Types shared by the hub config slave
package shc_pkg;

  // Slave engine states
  typedef enum logic [3:0] {
    SHC_IDLE = 4'b0000,
    SHC_ADDR = 4'b0001,
    SHC_ADDR_ACK = 4'b0010,
    SHC_REG = 4'b0011,
    SHC_REG_ACK = 4'b0100,
    SHC_DATA = 4'b0101,
    SHC_DATA_ACK = 4'b0110,
    SHC_STOP_WAIT = 4'b0111,
    SHC_TX = 4'b1000,
    SHC_IGNORE = 4'b1001
  } shc_state_t;

  // Configuration bytes as stored
  typedef struct packed {
    logic [7:0] port_disable_bus_powered;
    logic [7:0] max_power_self_powered;
    logic [7:0] max_power_bus_powered;
    logic [7:0] controller_current_self_powered;
    logic [7:0] controller_current_bus_powered;
    logic [7:0] port_power_good_delay;
  } shc_cfg_t;

  // Decoded physical values for the hub core
  typedef struct packed {
    logic [3:1] port_disabled;
    logic [8:0] max_power_self_ma;
    logic [8:0] max_power_bus_ma;
    logic [8:0] ctrl_current_self_ma;
    logic [8:0] ctrl_current_bus_ma;
    logic [8:0] power_good_delay_ms;
  } shc_cfg_phys_t;

endpackage

// >>> hdl/shc_top.sv
// SMBus slave-only configuration byte store for a three-port hub
`timescale 1ns/1ps
`default_nettype none
`include "shc_defines.svh"

// Contract
// - Port-disable bits 3..1 disable ports 3..1
// - Self-powered max power in 2 mA units
// - Bus-powered max power in 2 mA units
// - Self controller current 2 mA, default 50
// - Bus controller current 2 mA, default 50
// - Power-good delay counted in 2 ms units
// - SMBus strap uses pins as slave, no EEPROM
// - Wait forever, attach only after download
// - Slave only; Write Byte and Read Byte
// - 7-bit address, 8-bit register, 8-bit data
// - Register field selects; data written or returned
// - Drive data line only in own fields
// - Write sequence, bytes MSB first
// - Read uses repeated start, host NACKs, stop
// - Bad protocol or address: no change, idle
// - Start then stop resets to idle
module shc_top
  import shc_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Configuration strap pins
  input wire logic i_config_select_high,
  input wire logic i_config_select_low,
  // SMBus pins, open drain
  input wire logic i_smb_clk,
  input wire logic i_smb_dat,
  output logic o_smb_dat,
  output logic o_smb_dat_oe,
  // Hub core side
  output logic o_smbus_mode,
  output logic o_usb_attach_en,
  output shc_cfg_t o_cfg,
  output shc_cfg_phys_t o_cfg_phys
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic [1:0] sel_hi_sync_ff;
  logic [1:0] sel_lo_sync_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;
  shc_state_t state_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [7:0] reg_idx_ff;
  logic [7:0] wr_data_ff;
  logic reg_valid_ff;
  logic ack_hold_ff;
  logic oe_ff;
  logic done_ff;
  shc_cfg_t cfg_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [7:0] byte_in;
  logic smbus_mode;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Register index decode for the ack decision; the read mux decodes the index on its own
  function automatic logic idx_valid(input logic [7:0] idx);
    idx_valid = (idx >= `SHC_REG_PORT_DIS_BUS && idx <= `SHC_REG_PGOOD_DELAY) ||
                (idx == `SHC_REG_DL_DONE);
  endfunction

  function automatic logic [7:0] rd_mux(input logic [7:0] idx, input shc_cfg_t c,
                                        input logic dn);
    case (idx)
      `SHC_REG_PORT_DIS_BUS: rd_mux = c.port_disable_bus_powered & `SHC_PORT_DIS_MASK;
      `SHC_REG_MAXP_SELF: rd_mux = c.max_power_self_powered;
      `SHC_REG_MAXP_BUS: rd_mux = c.max_power_bus_powered;
      `SHC_REG_CTRL_I_SELF: rd_mux = c.controller_current_self_powered;
      `SHC_REG_CTRL_I_BUS: rd_mux = c.controller_current_bus_powered;
      `SHC_REG_PGOOD_DELAY: rd_mux = c.port_power_good_delay;
      `SHC_REG_DL_DONE: rd_mux = {7'h00, dn};
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // Scale a byte by a small unit into a 9-bit quantity
  function automatic logic [8:0] scale2(input logic [7:0] v);
    scale2 = 9'(v) * 9'(`SHC_UNIT_MA);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two flops on every pin; only stage one feeds stage two
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_sync_ff <= 2'b11;
      sda_sync_ff <= 2'b11;
      sel_hi_sync_ff <= 2'b00;
      sel_lo_sync_ff <= 2'b00;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], i_smb_clk};
      sda_sync_ff <= {sda_sync_ff[0], i_smb_dat};
      sel_hi_sync_ff <= {sel_hi_sync_ff[0], i_config_select_high};
      sel_lo_sync_ff <= {sel_lo_sync_ff[0], i_config_select_low};
    end
  end

  // Previous synchronised levels for edge detection
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
    end
  end

  // Bus events; start/stop only while the clock line stays high
  assign scl_rise = scl_sync_ff[1] & ~scl_prev_ff;
  assign scl_fall = ~scl_sync_ff[1] & scl_prev_ff;
  assign start_det = scl_sync_ff[1] & scl_prev_ff & sda_prev_ff & ~sda_sync_ff[1];
  assign stop_det = scl_sync_ff[1] & scl_prev_ff & ~sda_prev_ff & sda_sync_ff[1];
  assign byte_in = {shift_ff[6:0], sda_sync_ff[1]};
  assign smbus_mode = ({sel_hi_sync_ff[1], sel_lo_sync_ff[1]} == `SHC_SEL_SMBUS);

  // ----------------------------------------
  // Slave protocol engine
  // ----------------------------------------
  // Never drives the clock line and never starts a transfer
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= SHC_IDLE;
      bit_cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      reg_idx_ff <= 8'h00;
      wr_data_ff <= 8'h00;
      reg_valid_ff <= 1'b0;
      ack_hold_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (start_det) begin
      // Repeated start keeps the register index for a read
      state_ff <= smbus_mode ? SHC_ADDR : SHC_IGNORE;
      bit_cnt_ff <= 3'h0;
      ack_hold_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= SHC_IDLE;
      reg_valid_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (scl_rise) begin
      // Ack clock must not push the R/W bit out before it is acted on
      shift_ff <= (state_ff == SHC_ADDR_ACK) ? shift_ff : byte_in;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      case (state_ff)
        SHC_ADDR: begin
          if (bit_cnt_ff == `SHC_BYTE_LAST) begin
            // Own address only; read needs a register index first
            if (byte_in[7:1] != `SHC_SLAVE_ADDR) begin
              state_ff <= SHC_IGNORE;
            end else if (byte_in[0] && !reg_valid_ff) begin
              state_ff <= SHC_IGNORE;
            end else begin
              state_ff <= SHC_ADDR_ACK;
            end
          end
        end
        SHC_REG: begin
          if (bit_cnt_ff == `SHC_BYTE_LAST) begin
            reg_idx_ff <= byte_in;
            state_ff <= idx_valid(byte_in) ? SHC_REG_ACK : SHC_IGNORE;
          end
        end
        SHC_DATA: begin
          if (bit_cnt_ff == `SHC_BYTE_LAST) begin
            wr_data_ff <= byte_in;
            state_ff <= SHC_DATA_ACK;
          end
        end
        SHC_TX: begin
          tx_ff <= {tx_ff[6:0], 1'b0};
          if (bit_cnt_ff == `SHC_BYTE_LAST) begin
            state_ff <= SHC_IGNORE;
          end
        end
        // The stop's own clock rise lands here and must keep the commit
        default: begin
          state_ff <= state_ff;
        end
      endcase
    end else if (scl_fall) begin
      case (state_ff)
        SHC_ADDR_ACK, SHC_REG_ACK, SHC_DATA_ACK: begin
          if (!ack_hold_ff) begin
            ack_hold_ff <= 1'b1;
            oe_ff <= 1'b1;
          end else begin
            ack_hold_ff <= 1'b0;
            bit_cnt_ff <= 3'h0;
            oe_ff <= 1'b0;
            if (state_ff == SHC_ADDR_ACK && shift_ff[0]) begin
              tx_ff <= rd_mux(reg_idx_ff, cfg_ff, done_ff);
              oe_ff <= ~rd_mux(reg_idx_ff, cfg_ff, done_ff) >> 7 == 8'h01;
              state_ff <= SHC_TX;
            end else if (state_ff == SHC_ADDR_ACK) begin
              state_ff <= SHC_REG;
            end else if (state_ff == SHC_REG_ACK) begin
              reg_valid_ff <= 1'b1;
              state_ff <= SHC_DATA;
            end else begin
              state_ff <= SHC_STOP_WAIT;
            end
          end
        end
        SHC_TX: begin
          oe_ff <= ~tx_ff[7];
        end
        // A falling clock after the data ack means an extra byte began
        SHC_STOP_WAIT: begin
          state_ff <= SHC_IGNORE;
          oe_ff <= 1'b0;
        end
        default: begin
          oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Configuration bytes
  // ----------------------------------------
  // Commit only on the stop that closes a full Write Byte
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_ff.port_disable_bus_powered <= `SHC_RST_PORT_DIS;
      cfg_ff.max_power_self_powered <= `SHC_RST_MAXP;
      cfg_ff.max_power_bus_powered <= `SHC_RST_MAXP;
      cfg_ff.controller_current_self_powered <= `SHC_RST_CTRL_I;
      cfg_ff.controller_current_bus_powered <= `SHC_RST_CTRL_I;
      cfg_ff.port_power_good_delay <= `SHC_RST_PGOOD;
      done_ff <= 1'b0;
    end else if (stop_det && state_ff == SHC_STOP_WAIT) begin
      case (reg_idx_ff)
        `SHC_REG_PORT_DIS_BUS:
          cfg_ff.port_disable_bus_powered <= wr_data_ff & `SHC_PORT_DIS_MASK;
        `SHC_REG_MAXP_SELF: cfg_ff.max_power_self_powered <= wr_data_ff;
        `SHC_REG_MAXP_BUS: cfg_ff.max_power_bus_powered <= wr_data_ff;
        `SHC_REG_CTRL_I_SELF: cfg_ff.controller_current_self_powered <= wr_data_ff;
        `SHC_REG_CTRL_I_BUS: cfg_ff.controller_current_bus_powered <= wr_data_ff;
        `SHC_REG_PGOOD_DELAY: cfg_ff.port_power_good_delay <= wr_data_ff;
        // Done is sticky: once attached the hub never detaches here
        `SHC_REG_DL_DONE: done_ff <= done_ff | wr_data_ff[`SHC_DL_DONE_BIT];
        default: done_ff <= done_ff;
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Pull low only; the wire level is resolved outside
  assign o_smb_dat = 1'b0;
  assign o_smb_dat_oe = oe_ff;
  assign o_smbus_mode = smbus_mode;
  // No time limit on the download; other modes attach at once
  assign o_usb_attach_en = smbus_mode ? done_ff : 1'b1;
  assign o_cfg = cfg_ff;

  // Physical values; self-powered limit of 50 is the host's duty
  assign o_cfg_phys.port_disabled = cfg_ff.port_disable_bus_powered[3:1];
  assign o_cfg_phys.max_power_self_ma = scale2(cfg_ff.max_power_self_powered);
  assign o_cfg_phys.max_power_bus_ma = scale2(cfg_ff.max_power_bus_powered);
  assign o_cfg_phys.ctrl_current_self_ma =
    scale2(cfg_ff.controller_current_self_powered);
  assign o_cfg_phys.ctrl_current_bus_ma =
    scale2(cfg_ff.controller_current_bus_powered);
  assign o_cfg_phys.power_good_delay_ms =
    9'(cfg_ff.port_power_good_delay) * 9'(`SHC_UNIT_MS);

endmodule // shc_top
`default_nettype wire

// >>> verification/shc_host_model.sv
// Behavioural SMBus host that loads the hub configuration
`timescale 1ns/1ps
`default_nettype none
module shc_host_model (
  // Core clock paces the bus phases
  input wire logic i_core_clk,
  input wire logic i_sda,
  // Open-drain drives and read result
  output logic o_scl,
  output logic o_sda_low,
  output logic o_rd_vld,
  output logic [7:0] o_rd_data
);
  // Bus idle, both lines released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    o_rd_vld = 1'b0;
    o_rd_data = 8'h00;
  end
  // Phases of 12 clocks so every level survives the pin synchronisers
  task automatic w(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    o_sda_low = 1'b0;
    w(12);
    o_scl = 1'b1;
    w(12);
    o_sda_low = 1'b1;
    w(12);
    o_scl = 1'b0;
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    w(3);
    o_sda_low = 1'b1;
    w(12);
    o_scl = 1'b1;
    w(12);
    o_sda_low = 1'b0;
    w(12);
  endtask
  // Byte plus acknowledge bit, most significant first; a one releases the line
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      w(3);
      o_sda_low = !d[i];
      w(12);
      o_scl = 1'b1;
      w(12);
      q[i] = i_sda;
      o_scl = 1'b0;
    end
  endtask
  // Write Byte, or Read Byte when rd is set; ack high when every byte was taken
  task automatic access(input logic rd, input logic [6:0] sa, input logic [7:0] rg,
                        input logic [7:0] d, output logic ack);
    logic [8:0] q1, q2, q3, q4;
    start();
    xfer({sa, 1'b0, 1'b1}, q1);
    xfer({rg, 1'b1}, q2);
    if (rd) begin
      start();
      xfer({sa, 1'b1, 1'b1}, q3);
      xfer(9'h1FF, q4);
      o_rd_data = q4[8:1];
      o_rd_vld = 1'b1;
    end else begin
      xfer({d, 1'b1}, q3);
    end
    stop();
    o_rd_vld = 1'b0;
    ack = !q1[0] && !q2[0] && !q3[0];
  endtask
endmodule // shc_host_model
`default_nettype wire

// >>> verification/shc_top_sva.sv
// Port-level checker for the hub config slave
`timescale 1ns/1ps
`default_nettype none
module shc_top_sva
  import shc_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Watched pins and outputs
  input wire logic i_smb_clk,
  input wire logic i_smb_dat,
  input wire logic o_smb_dat_oe,
  input wire logic o_smbus_mode,
  input wire logic o_usb_attach_en,
  input wire shc_cfg_t o_cfg,
  input wire shc_cfg_phys_t o_cfg_phys
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // Cycles since a stop on the pins; saturates so it never wraps back to young
  logic [3:0] stop_age_ff;
  logic dat_ff;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stop_age_ff <= 4'hF;
      dat_ff <= 1'b1;
    end else begin
      dat_ff <= i_smb_dat;
      if (i_smb_clk && i_smb_dat && !dat_ff) stop_age_ff <= 4'h0;
      else if (stop_age_ff != 4'hF) stop_age_ff <= stop_age_ff + 4'h1;
    end
  end
  // Stop on the pins, and the download flag rising in bus mode
  sequence s_stop; i_smb_clk && $rose(i_smb_dat); endsequence
  sequence s_done; $rose(o_usb_attach_en) && o_smbus_mode; endsequence
  property p_oe_hold; i_smb_clk && $past(i_smb_clk) |-> $stable(o_smb_dat_oe); endproperty
  property p_idle; s_stop |=> (!o_smb_dat_oe) [*8]; endproperty
  property p_cfg_stop; $changed(o_cfg) |-> stop_age_ff < 4'hA; endproperty
  property p_rst; $rose(i_rst_b) |-> o_cfg == 48'h0000_0032_3200; endproperty
  property p_resv; o_cfg[47:44] == 4'h0 && !o_cfg[40]; endproperty
  property p_mode; !o_smbus_mode |-> ##[0:2] o_usb_attach_en; endproperty
  property p_done; s_done |-> stop_age_ff < 4'hA ##1 o_usb_attach_en [*8]; endproperty
  property p_phys;
    1'b1 |-> ##[0:1] o_cfg_phys == {o_cfg[43:41], o_cfg[39:32], 1'b0, o_cfg[31:24], 1'b0,
      o_cfg[23:16], 1'b0, o_cfg[15:8], 1'b0, o_cfg[7:0], 1'b0};
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("data drive moved in clock high");
  a_idle: assert property (p_idle) else $error("data driven after stop");
  a_cfg_stop: assert property (p_cfg_stop) else $error("bytes changed away from stop");
  a_rst: assert property (p_rst) else $error("bytes not at defaults");
  a_resv: assert property (p_resv) else $error("reserved bits set");
  a_mode: assert property (p_mode) else $error("attach held off outside bus mode");
  a_done: assert property (p_done) else $error("attach not sticky after stop");
  a_phys: assert property (p_phys) else $error("decoded values wrong");
endmodule // shc_top_sva
bind shc_top shc_top_sva u_sva (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_smb_clk(i_smb_clk), .i_smb_dat(i_smb_dat),
  .o_smb_dat_oe(o_smb_dat_oe), .o_smbus_mode(o_smbus_mode),
  .o_usb_attach_en(o_usb_attach_en), .o_cfg(o_cfg), .o_cfg_phys(o_cfg_phys)
);
`default_nettype wire

// >>> verification/tb_smbus_hub_config_slave.sv
// Self-checking bench for the hub config slave
`timescale 1ns/1ps
`default_nettype none
module tb_smbus_hub_config_slave
  import shc_pkg::*;
;
  logic clk, rst_b, scl, host_low, rd_vld, dut_dat, dut_oe, mode, attach;
  logic sel_hi, sel_lo;
  logic [7:0] rd_data;
  logic [7:0] eb [6];
  logic [7:0] exp_q [$];
  wire sda;
  shc_cfg_t cfg;
  shc_cfg_phys_t phys;
  integer seed = 6;
  int error_cnt = 0;
  int num_checks = 0;
  // Pulled up wire: any party pulling low wins
  assign sda = !(host_low || (dut_oe && !dut_dat));
  shc_top dut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_config_select_high(sel_hi),
    .i_config_select_low(sel_lo), .i_smb_clk(scl), .i_smb_dat(sda), .o_smb_dat(dut_dat),
    .o_smb_dat_oe(dut_oe), .o_smbus_mode(mode), .o_usb_attach_en(attach), .o_cfg(cfg),
    .o_cfg_phys(phys)
  );
  shc_host_model u_host (
    .i_core_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low), .o_rd_vld(rd_vld),
    .o_rd_data(rd_data)
  );
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cycle ceiling; the full run needs about 16000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One access; a read notes its expected byte first
  task automatic acc(input logic rd, input logic [6:0] sa, input logic [7:0] rg,
                     input logic [7:0] d, input logic ea);
    logic ack;
    if (rd) exp_q.push_back(d);
    u_host.access(rd, sa, rg, d, ack);
    chk("ack", 48'(ea), 48'(ack));
  endtask
  // Each byte the host reads is matched against the oldest note
  always begin
    @(posedge rd_vld);
    chk("read", 48'(exp_q.pop_front()), 48'(rd_data));
  end
  // Main sequence
  initial begin
    logic [7:0] d;
    logic [47:0] kept;
    rst_b = 1'b0;
    {sel_hi, sel_lo} = 2'b10;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
    // Another strap code: no bus port, attach at once, writes refused
    chk("mode attach", 48'h1, 48'({mode, attach}));
    acc(1'b0, 7'h2C, 8'h0C, 8'h5A, 1'b0);
    chk("cfg reset", 48'h0000_0032_3200, cfg);
    {sel_hi, sel_lo} = 2'b11;
    repeat (6) @(negedge clk);
    chk("mode attach", 48'h2, 48'({mode, attach}));
    for (int r = 0; r < 6; r++) begin
      d = 8'($random(seed));
      if (r == 0) d = d | 8'hF1;
      if (r == 1) d = {3'b000, d[4:0]} + 8'h13;
      eb[r] = (r == 0) ? (d & 8'h0E) : d;
      acc(1'b0, 7'h2C, 8'h0A + 8'(r), d, 1'b1);
      acc(1'b1, 7'h2C, 8'h0A + 8'(r), eb[r], 1'b1);
    end
    chk("cfg", {eb[0], eb[1], eb[2], eb[3], eb[4], eb[5]}, cfg);
    chk("phys", {eb[0][3:1], eb[1], 1'b0, eb[2], 1'b0, eb[3], 1'b0, eb[4], 1'b0,
                 eb[5], 1'b0}, phys);
    kept = cfg;
    acc(1'b0, 7'h2D, 8'h0C, 8'hA5, 1'b0);
    acc(1'b0, 7'h2C, 8'h20, 8'hA5, 1'b0);
    chk("cfg kept", kept, cfg);
    u_host.start();
    u_host.stop();
    chk("attach early", 48'h0, 48'(attach));
    acc(1'b0, 7'h2C, 8'h1F, 8'h01, 1'b1);
    repeat (8) @(negedge clk);
    chk("attach", 48'h1, 48'(attach));
    acc(1'b1, 7'h2C, 8'h0B, eb[1], 1'b1);
    end_sim();
  end
endmodule // tb_smbus_hub_config_slave
`default_nettype wire
